/* File: core/spaf_map.vh */
// Register offsets, field positions, reset values and sizes of the port filter
`ifndef SPAF_MAP_VH
`define SPAF_MAP_VH
`define SPAF_NPORTS        12
`define SPAF_VID_W         12
`define SPAF_NVLANS        4095
`define SPAF_NRSV          16
`define SPAF_NAGGR         16
// Register word addresses (8-bit address space)
`define SPAF_A_LEARN_ON    8'h00
`define SPAF_A_VLAN_FILT   8'h01
`define SPAF_A_ADV_LEARN   8'h02
`define SPAF_A_QSEL_LO     8'h03
`define SPAF_A_QSEL_HI     8'h04
`define SPAF_A_VT_INDEX    8'h05
`define SPAF_A_VT_DATA     8'h06
`define SPAF_A_VT_CMD      8'h07
`define SPAF_A_STATUS      8'h08
`define SPAF_A_REDIR_BASE  8'h10
`define SPAF_A_AGGR_BASE   8'h20
`define SPAF_A_SRC_BASE    8'h30
// Field positions
`define SPAF_VT_SRCCHK_BIT 12
`define SPAF_ADV_VLANCHK   0
`define SPAF_CMD_READ      2'h1
`define SPAF_CMD_WRITE     2'h2
// Reset values
`define SPAF_RST_MASK      12'h000
`define SPAF_RST_REDIR     16'h0000
`define SPAF_RST_QSEL      24'h00_0000
`endif

/* File: core/spaf_vlan_mem.v */
// VLAN table memory: member port mask plus ingress filter bit per VLAN
`timescale 1ns/1ns
module spaf_vlan_mem
(
	input  wire        clock_i,    // System clock
	input  wire        wr_i,       // Write strobe
	input  wire [11:0] waddr_i,    // Write VLAN index
	input  wire [12:0] wdata_i,    // {filter bit, member ports}
	input  wire [11:0] raddr_i,    // Read VLAN index
	output reg  [12:0] rdata_o     // Registered read data
);
	reg [12:0] mem [0:4095];

	always @(posedge clock_i)
	begin
		if (wr_i)
			mem[waddr_i] <= wdata_i;
		rdata_o <= mem[raddr_i];
	end
endmodule // spaf_vlan_mem

/* File: core/spaf_filter.v */
// Spanning tree and access control frame filter of the frame analyzer
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "spaf_map.vh"
module spaf_filter
(
	input  wire        clock_i,       // 10 MHz clock
	input  wire        reset_i,       // Synchronous reset, active high
	input  wire [7:0]  addr_i,        // Register address
	input  wire [31:0] wdata_i,       // Register write data
	input  wire        wr_i,          // Write strobe
	input  wire        rd_i,          // Read strobe
	output reg  [31:0] rdata_o,       // Read data, cycle after rd_i
	input  wire        frm_valid_i,   // Frame decision request
	input  wire [3:0]  frm_port_i,    // Ingress port
	input  wire [11:0] frm_vid_i,     // Classified VLAN
	input  wire [47:0] frm_dmac_i,    // Destination MAC
	input  wire [11:0] frm_dst_i,     // Destination port mask
	input  wire [3:0]  frm_aggr_i,    // Aggregation code
	output reg         dec_valid_o,   // Decision valid pulse
	output reg  [11:0] dec_egress_o,  // Egress port set
	output reg         dec_learn_o,   // Learn source address
	output reg         dec_cpu_o,     // Redirect to CPU
	output reg  [3:0]  dec_cpuq_o,    // CPU extraction queue
	output reg         dec_vdrop_o    // Dropped by VLAN filtering
);
	localparam [47:0] RSV_BASE = 48'h0180_C200_0000;

	reg  [11:0] source_address_learning_on_ff;
	reg  [11:0] port_vlan_filter_enables_ff;
	reg         no_learn_on_vlan_discard_ff;
	reg  [2:0]  redirect_queue_select_ff [0:15];
	reg  [15:0] reserved_addr_redirect_on_ff [0:11];
	reg  [11:0] aggr_mask_ff [0:15];
	reg  [11:0] src_mask_ff [0:11];
	reg  [11:0] vlan_table_index_ff;
	reg  [12:0] vt_data_ff;
	reg  [11:0] vt_hits_ff;
	reg         vt_rd_pend_ff;
	reg         rd_pend_ff;
	reg  [7:0]  rd_addr_ff;
	reg         f_valid_ff;
	reg  [3:0]  f_port_ff;
	reg  [47:0] f_dmac_ff;
	reg  [11:0] f_dst_ff;
	reg  [3:0]  f_aggr_ff;
	wire [12:0] vt_rdata;
	reg  [11:0] mem_raddr;
	reg         vt_wr;
	reg         vt_rd_cmd;
	integer     i;

	// Table read port is shared: a software read wins over a frame lookup
	always @*
	begin
		vt_rd_cmd = wr_i && addr_i == `SPAF_A_VT_CMD && wdata_i[1:0] == `SPAF_CMD_READ;
		// Index 0 is not a VLAN, writes to it are dropped
		vt_wr     = wr_i && addr_i == `SPAF_A_VT_CMD && wdata_i[1:0] == `SPAF_CMD_WRITE
		            && vlan_table_index_ff != 12'h000;
		mem_raddr = frm_vid_i;
		if (vt_rd_cmd)
			mem_raddr = vlan_table_index_ff;
	end

	spaf_vlan_mem u_vlan_mem
	(
		.clock_i (clock_i),
		.wr_i    (vt_wr),
		.waddr_i (vlan_table_index_ff),
		.wdata_i (vt_data_ff),
		.raddr_i (mem_raddr),
		.rdata_o (vt_rdata)
	);

	// Register writes
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			source_address_learning_on_ff <= `SPAF_RST_MASK;
			port_vlan_filter_enables_ff   <= `SPAF_RST_MASK;
			no_learn_on_vlan_discard_ff   <= 1'b0;
			vlan_table_index_ff           <= 12'h000;
			vt_data_ff                    <= 13'h0000;
			vt_rd_pend_ff                 <= 1'b0;
			for (i = 0; i < 16; i = i + 1)
			begin
				redirect_queue_select_ff[i] <= 3'h0;
				aggr_mask_ff[i]             <= `SPAF_RST_MASK;
			end
			for (i = 0; i < 12; i = i + 1)
			begin
				reserved_addr_redirect_on_ff[i] <= `SPAF_RST_REDIR;
				src_mask_ff[i]                  <= `SPAF_RST_MASK;
			end
		end
		else
		begin
			vt_rd_pend_ff <= vt_rd_cmd;
			if (vt_rd_pend_ff)
				vt_data_ff <= vt_rdata;
			if (wr_i)
			begin
				if (addr_i == `SPAF_A_LEARN_ON)
					source_address_learning_on_ff <= wdata_i[11:0];
				else if (addr_i == `SPAF_A_VLAN_FILT)
					port_vlan_filter_enables_ff <= wdata_i[11:0];
				else if (addr_i == `SPAF_A_ADV_LEARN)
					no_learn_on_vlan_discard_ff <= wdata_i[`SPAF_ADV_VLANCHK];
				else if (addr_i == `SPAF_A_QSEL_LO)
				begin
					for (i = 0; i < 8; i = i + 1)
						redirect_queue_select_ff[i] <= wdata_i[3*i +: 3];
				end
				else if (addr_i == `SPAF_A_QSEL_HI)
				begin
					for (i = 0; i < 8; i = i + 1)
						redirect_queue_select_ff[i+8] <= wdata_i[3*i +: 3];
				end
				else if (addr_i == `SPAF_A_VT_INDEX)
					vlan_table_index_ff <= wdata_i[11:0];
				else if (addr_i == `SPAF_A_VT_DATA)
					vt_data_ff <= wdata_i[12:0];
				else if (addr_i[7:4] == 4'h1 && addr_i[3:0] < 4'd12)
					reserved_addr_redirect_on_ff[addr_i[3:0]] <= wdata_i[15:0];
				else if (addr_i[7:4] == 4'h2)
					aggr_mask_ff[addr_i[3:0]] <= wdata_i[11:0];
				else if (addr_i[7:4] == 4'h3 && addr_i[3:0] < 4'd12)
					src_mask_ff[addr_i[3:0]] <= wdata_i[11:0];
			end
		end
	end

	// Register reads, data in the following cycle
	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= 8'h00;
			rdata_o    <= 32'h0000_0000;
		end
		else
		begin
			rd_pend_ff <= rd_i;
			rd_addr_ff <= addr_i;
			rdata_o    <= 32'h0000_0000;
			if (rd_i)
			begin
				if (addr_i == `SPAF_A_LEARN_ON)
					rdata_o <= {20'h0_0000, source_address_learning_on_ff};
				else if (addr_i == `SPAF_A_VLAN_FILT)
					rdata_o <= {20'h0_0000, port_vlan_filter_enables_ff};
				else if (addr_i == `SPAF_A_ADV_LEARN)
					rdata_o <= {31'h0000_0000, no_learn_on_vlan_discard_ff};
				else if (addr_i == `SPAF_A_QSEL_LO)
					rdata_o <= {8'h00, redirect_queue_select_ff[7], redirect_queue_select_ff[6],
					            redirect_queue_select_ff[5], redirect_queue_select_ff[4],
					            redirect_queue_select_ff[3], redirect_queue_select_ff[2],
					            redirect_queue_select_ff[1], redirect_queue_select_ff[0]};
				else if (addr_i == `SPAF_A_QSEL_HI)
					rdata_o <= {8'h00, redirect_queue_select_ff[15], redirect_queue_select_ff[14],
					            redirect_queue_select_ff[13], redirect_queue_select_ff[12],
					            redirect_queue_select_ff[11], redirect_queue_select_ff[10],
					            redirect_queue_select_ff[9], redirect_queue_select_ff[8]};
				else if (addr_i == `SPAF_A_VT_INDEX)
					rdata_o <= {20'h0_0000, vlan_table_index_ff};
				else if (addr_i == `SPAF_A_VT_DATA)
					rdata_o <= {19'h0_0000, vt_data_ff};
				else if (addr_i == `SPAF_A_STATUS)
					rdata_o <= {20'h0_0000, vt_hits_ff};
				else if (addr_i[7:4] == 4'h1 && addr_i[3:0] < 4'd12)
					rdata_o <= {16'h0000, reserved_addr_redirect_on_ff[addr_i[3:0]]};
				else if (addr_i[7:4] == 4'h2)
					rdata_o <= {20'h0_0000, aggr_mask_ff[addr_i[3:0]]};
				else if (addr_i[7:4] == 4'h3 && addr_i[3:0] < 4'd12)
					rdata_o <= {20'h0_0000, src_mask_ff[addr_i[3:0]]};
			end
		end
	end

	// Frame decision, stage two uses the VLAN entry read in stage one
	reg         rsv_hit;
	reg  [3:0]  rsv_idx;
	reg         vfilter;
	reg         vdrop;
	reg         redir;
	reg  [11:0] egress;

	always @*
	begin
		rsv_hit = f_dmac_ff[47:4] == RSV_BASE[47:4];
		rsv_idx = f_dmac_ff[3:0];
		vfilter = vt_rdata[`SPAF_VT_SRCCHK_BIT] || port_vlan_filter_enables_ff[f_port_ff];
		vdrop   = vfilter && !vt_rdata[f_port_ff];
		// Index 3 redirect ignores authentication masks as well
		redir   = rsv_hit && reserved_addr_redirect_on_ff[f_port_ff][rsv_idx];
		egress  = f_dst_ff & src_mask_ff[f_port_ff] & aggr_mask_ff[f_aggr_ff];
		if (vdrop || redir)
			egress = 12'h000;
	end

	// Sticky VLAN drop flags, write one to clear
	reg  [11:0] vdrop_set;
	reg  [11:0] sts_clr;
	reg  [11:0] nxt_vt_hits;

	always @*
	begin
		vdrop_set = 12'h000;
		if (f_valid_ff && vdrop)
			vdrop_set[f_port_ff] = 1'b1;
		sts_clr = 12'h000;
		if (wr_i && addr_i == `SPAF_A_STATUS)
			sts_clr = wdata_i[11:0];
		// Other flags still clear when a new drop lands; the new drop wins
		nxt_vt_hits = (vt_hits_ff & ~sts_clr) | vdrop_set;
	end

	always @(posedge clock_i)
	begin
		if (reset_i)
		begin
			f_valid_ff   <= 1'b0;
			f_port_ff    <= 4'h0;
			f_dmac_ff    <= 48'h0000_0000_0000;
			f_dst_ff     <= 12'h000;
			f_aggr_ff    <= 4'h0;
			dec_valid_o  <= 1'b0;
			dec_egress_o <= 12'h000;
			dec_learn_o  <= 1'b0;
			dec_cpu_o    <= 1'b0;
			dec_cpuq_o   <= 4'h0;
			dec_vdrop_o  <= 1'b0;
			vt_hits_ff   <= 12'h000;
		end
		else
		begin
			// Table port busy with a software read: the frame is dropped
			f_valid_ff   <= frm_valid_i && !vt_rd_cmd;
			f_port_ff    <= frm_port_i < 4'd12 ? frm_port_i : 4'h0;
			f_dmac_ff    <= frm_dmac_i;
			f_dst_ff     <= frm_dst_i;
			f_aggr_ff    <= frm_aggr_i;
			dec_valid_o  <= f_valid_ff;
			dec_egress_o <= f_valid_ff ? egress : 12'h000;
			dec_learn_o  <= f_valid_ff && source_address_learning_on_ff[f_port_ff]
			                && !(vdrop && no_learn_on_vlan_discard_ff);
			dec_cpu_o    <= f_valid_ff && redir;
			dec_cpuq_o   <= {1'b0, redirect_queue_select_ff[rsv_idx]};
			dec_vdrop_o  <= f_valid_ff && vdrop;
			vt_hits_ff   <= nxt_vt_hits;
		end
	end
endmodule // spaf_filter

/* File: testbench/spaf_filter_properties.sv */
// Port-level checks of the frame filter
`timescale 1ns/1ns
module spaf_filter_chk
(
	input wire        clock_i,      // Clock
	input wire        reset_i,      // Reset
	input wire [7:0]  addr_i,       // Address
	input wire [31:0] wdata_i,      // Write data
	input wire        wr_i,         // Write strobe
	input wire        rd_i,         // Read strobe
	input wire [31:0] rdata_o,      // Read data
	input wire        frm_valid_i,  // Request
	input wire [47:0] frm_dmac_i,   // Destination MAC
	input wire [11:0] frm_dst_i,    // Destination mask
	input wire        dec_valid_o,  // Decision valid
	input wire [11:0] dec_egress_o, // Egress set
	input wire        dec_learn_o,  // Learn
	input wire        dec_cpu_o,    // To CPU
	input wire        dec_vdrop_o   // VLAN drop
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	AST_DEC_LAT: assert property (frm_valid_i && !(wr_i && addr_i == 8'h07 && wdata_i[1:0] == 2'h1)
		|-> ##2 dec_valid_o) else $error("decision missing");
	AST_DEC_CAUSE: assert property (dec_valid_o |-> $past(frm_valid_i, 2)) else $error("stray decision");
	AST_QUIET: assert property (!dec_valid_o |-> {dec_egress_o, dec_learn_o, dec_cpu_o, dec_vdrop_o} == 15'h0000)
		else $error("outputs not idle");
	AST_CPU_EXEMPT: assert property (dec_cpu_o |-> dec_egress_o == 12'h000) else $error("redirect forwarded");
	AST_VDROP_BLOCK: assert property (dec_vdrop_o |-> dec_egress_o == 12'h000) else $error("drop forwarded");
	AST_IN_DST: assert property (dec_valid_o |-> (dec_egress_o & ~$past(frm_dst_i, 2)) == 12'h000)
		else $error("egress outside destination");
	AST_CPU_RSV: assert property (dec_cpu_o |-> ($past(frm_dmac_i, 2) & 48'hFFFF_FFFF_FFF0) == 48'h0180_C200_0000)
		else $error("redirect of ordinary address");
	AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000) else $error("read data outside slot");
endmodule // spaf_filter_chk
bind spaf_filter spaf_filter_chk spaf_filter_chk_inst (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frm_valid_i(frm_valid_i),
	.frm_dmac_i(frm_dmac_i), .frm_dst_i(frm_dst_i), .dec_valid_o(dec_valid_o), .dec_egress_o(dec_egress_o),
	.dec_learn_o(dec_learn_o), .dec_cpu_o(dec_cpu_o), .dec_vdrop_o(dec_vdrop_o));

/* File: testbench/spaf_peer.sv */
// Frame source standing for the stations on the LAN ports
`timescale 1ns/1ns
module spaf_peer
(
	input  wire        clock_i,     // Clock
	input  wire        go_i,        // Send a frame
	input  wire [65:0] fld_i,       // {port, vid, dmac}
	input  wire [15:0] dsa_i,       // {dst, aggr}
	output reg         frm_valid_o, // Request
	output reg  [65:0] fld_o,       // Frame fields
	output reg  [15:0] dsa_o        // Masks
);
	initial
	begin
		frm_valid_o = 1'b0;
		fld_o = '0;
		dsa_o = '0;
	end
	// Idle fields toggle so nothing stale looks valid
	always @(posedge clock_i)
	begin
		frm_valid_o <= go_i;
		fld_o <= go_i ? fld_i : ~fld_o;
		dsa_o <= go_i ? dsa_i : ~dsa_o;
	end
endmodule // spaf_peer

/* File: testbench/tb_top.sv */
// Self-checking bench of the frame filter
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic        clock_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, go = 0, rd_d = 0, frm_valid_i, dec_valid_o;
	logic [7:0]  addr_i = 0;
	logic [31:0] wdata_i = 0, rdata_o;
	logic [65:0] fld = 0, pf;
	logic [15:0] dsa = 0, pd;
	logic [11:0] dec_egress_o, le, vfe, src[12], ag[16];
	logic        dec_learn_o, dec_cpu_o, dec_vdrop_o, nl;
	logic [3:0]  dec_cpuq_o;
	logic [15:0] red[12];
	logic [2:0]  qs[16];
	logic [12:0] vt[8];
	logic [18:0] eq[$], e;
	logic [31:0] rq[$], x;
	logic [11:0] hits = 12'h000;
	int          fail_count = 0, check_count = 0;
	always #50 clock_i = ~clock_i;
	spaf_peer spaf_peer_inst (.clock_i(clock_i), .go_i(go), .fld_i(fld), .dsa_i(dsa), .frm_valid_o(frm_valid_i),
		.fld_o(pf), .dsa_o(pd));
	spaf_filter spaf_filter_inst (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frm_valid_i(frm_valid_i), .frm_port_i(pf[65:62]),
		.frm_vid_i(pf[59:48]), .frm_dmac_i(pf[47:0]), .frm_dst_i(pd[15:4]), .frm_aggr_i(pd[3:0]),
		.dec_valid_o(dec_valid_o), .dec_egress_o(dec_egress_o), .dec_learn_o(dec_learn_o),
		.dec_cpu_o(dec_cpu_o), .dec_cpuq_o(dec_cpuq_o), .dec_vdrop_o(dec_vdrop_o));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge clock_i);
		wr_i <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1;
		rq.push_back(x);
		@(posedge clock_i);
		rd_i <= 0;
	endtask
	task automatic cfg(input bit st);
		logic [47:0] q;
		le = st ? 12'hFFF : 12'($urandom);
		vfe = st ? 12'h000 : 12'($urandom);
		nl = st ? 1'b1 : 1'($urandom);
		wr(8'h00, {20'h0_0000, le});
		wr(8'h01, {20'h0_0000, vfe});
		wr(8'h02, {31'h0000_0000, nl});
		for (int i = 0; i < 16; i++) qs[i] = 3'($urandom);
		for (int i = 0; i < 16; i++) q[3*i +: 3] = qs[i];
		wr(8'h03, {8'h00, q[23:0]});
		wr(8'h04, {8'h00, q[47:24]});
		for (int p = 0; p < 12; p++)
		begin
			red[p] = 16'($urandom) | (st ? 16'h0009 : 16'h0008);
			src[p] = (p == 0) ? 12'h000 : st ? ~(12'h001 << p) : 12'($urandom);
			wr(8'h10 + 8'(p), {16'h0000, red[p]});
			wr(8'h30 + 8'(p), {20'h0_0000, src[p]});
		end
		for (int n = 0; n < 16; n++)
		begin
			ag[n] = st ? 12'hFFF : 12'($urandom);
			wr(8'h20 + 8'(n), {20'h0_0000, ag[n]});
		end
		for (int v = 1; v < 8; v++)
		begin
			vt[v] = 13'($urandom) | (st ? 13'h1000 : 13'h0000);
			wr(8'h05, 32'(v));
			wr(8'h06, {19'h0_0000, vt[v]});
			wr(8'h07, 32'h0000_0002);
		end
		// Table read command loads the data register
		wr(8'h05, 32'h0000_0003);
		wr(8'h07, 32'h0000_0001);
		rd(8'h06, {19'h0_0000, vt[3]});
	endtask
	task automatic frames(input int n);
		logic [3:0]  p, a;
		logic [11:0] v, d, g;
		logic [47:0] m;
		logic        rs, vd;
		repeat (n)
		begin
			@(posedge clock_i);
			p = 4'($urandom % 12);
			v = 12'(1 + $urandom % 7);
			m = $urandom % 2 ? {44'h0180_C200_000, 4'($urandom)} : {16'($urandom), 32'($urandom)};
			d = 12'($urandom);
			a = 4'($urandom);
			rs = m[47:4] == 44'h0180_C200_000 && red[p][m[3:0]];
			vd = (vt[v][12] | vfe[p]) & ~vt[v][p];
			g = (vd | rs) ? 12'h000 : d & src[p] & ag[a];
			eq.push_back({g, le[p] & ~(vd & nl), rs, vd, 1'b0, qs[m[3:0]]});
			if (vd)
				hits[p] = 1'b1;
			go <= 1;
			fld <= {p, 2'b00, v, m};
			dsa <= {d, a};
		end
		@(posedge clock_i);
		go <= 0;
	endtask
	always @(posedge clock_i)
	begin
		if (rd_d)
		begin
			x = rq.pop_front();
			`CHK(rdata_o, x)
		end
		rd_d <= rd_i;
		if (dec_valid_o === 1'b1)
		begin
			`CHK(eq.size() != 0, 1'b1)
			e = eq.pop_front();
			`CHK({dec_egress_o, dec_learn_o, dec_cpu_o, dec_vdrop_o}, e[18:4])
			if (e[5]) `CHK(dec_cpuq_o, e[3:0])
		end
	end
	task give_verdict;
		`CHK(eq.size() + rq.size(), 0)
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#2_000_000;
		fail_count++;
		give_verdict;
	end
	initial
	begin
		void'($urandom(34));
		repeat (5) @(posedge clock_i);
		reset_i <= 0;
		rd(8'h00, 32'h0000_0000);
		for (int r = 0; r < 3; r++)
		begin
			if (r == 1)
			begin
				// Reset in mid-run clears the register masks and flags, not the VLAN table
				reset_i <= 1;
				repeat (2) @(posedge clock_i);
				reset_i <= 0;
				hits = 12'h000;
				rd(8'h30, 32'h0000_0000);
				rd(8'h08, 32'h0000_0000);
			end
			cfg(r == 2);
			rd(8'h00, {20'h0_0000, le});
			rd(8'h01, {20'h0_0000, vfe});
			rd(8'hFF, 32'h0000_0000);
			frames(80);
			if (r == 2)
			begin
				// Port 0 authenticates: its source mask comes back
				src[0] = 12'hFFE;
				wr(8'h30, {20'h0_0000, src[0]});
				frames(40);
			end
			repeat (3) @(posedge clock_i);
			rd(8'h08, {20'h0_0000, hits});
			wr(8'h08, {20'h0_0000, hits});
			hits = 12'h000;
			rd(8'h08, 32'h0000_0000);
		end
		repeat (10) @(posedge clock_i);
		give_verdict;
	end
endmodule // tb_top
